/* File: hw/pdcr_top.sv */
`timescale 1ns/1ps

// What this block does
// [R1] Address bit0 low loads main divider word
// [R2] Main feedback count is plain 11-bit binary
// [R3] Host keeps main count within 65..2045
// [R4] Edge main counts need low modulator order
// [R5] Reference divider divides by 1 to 63
// [R6] Power-down bit stops loop, pump high-impedance
// [R7] Enable low forces main loop down
// [R8] Auto power-up overrides power-down bit
// [R9] Aux split: swallow mod P, main div P; main count here is always field div 16
// [R10] Host keeps aux main count >= swallow
// [R11] Aux field plain binary, max 65535 small
// [R12] Host writes aux bit3 zero with 8/9
// [R13] Host keeps aux ratio at least 24
// [R14] Host uses only listed small aux ratios
// [R15] MSB-first shift, copy on strobe rise
// [R16] Decode 0001 denominator, 0011 auxiliary
// [R17] Main word write resets lock counters
// [R18] Aux power-down immediate or after pump idle
// [R19] Host never writes reference divider zero
// [R20] Partial words touch no register until a strobe; there is no bit count, so a strobe after a partial word still loads
module pdcr_top (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 ser_data,
    input  wire logic                 ser_clk,
    input  wire logic                 latch_strobe,
    input  wire logic                 chip_enable,
    input  wire logic [1:0]           auto_powerup_word,
    input  wire logic                 aux_pd_immediate,
    input  wire logic                 aux_pump_idle,
    input  wire logic                 ref_tick,
    output logic [10:0]               main_feedback_count,
    output logic [11:0]               main_fraction_numerator,
    output logic [11:0]               main_fraction_denominator,
    output logic [5:0]                main_reference_divider,
    output logic                      main_loop_powerdown_bit,
    output logic                      main_loop_powered_down,
    output logic                      main_cp_hiz,
    output logic                      ref_div_pulse,
    output logic                      lock_counters_reset,
    output logic [12:0]               aux_main_count,
    output logic [3:0]                aux_swallow_count,
    output logic                      aux_prescaler_16,
    output logic                      aux_cp_gain_high,
    output logic                      aux_loop_powerdown_bit,
    output logic                      aux_loop_powered_down,
    output logic                      aux_cp_hiz
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic data_s;
    logic sclk_s;
    logic strobe_s;
    logic enable_s;
    logic sclk_prev_q;
    logic strobe_prev_q;
    logic sclk_rise;
    logic strobe_rise;

    pdcr_sync u_sync_data (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .pin_in    (ser_data),
        .level_out (data_s)
    );

    pdcr_sync u_sync_sclk (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .pin_in    (ser_clk),
        .level_out (sclk_s)
    );

    pdcr_sync u_sync_strobe (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .pin_in    (latch_strobe),
        .level_out (strobe_s)
    );

    pdcr_sync u_sync_enable (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .pin_in    (chip_enable),
        .level_out (enable_s)
    );

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev_q   <= 1'b0;
            strobe_prev_q <= 1'b0;
        end else begin
            sclk_prev_q   <= sclk_s;
            strobe_prev_q <= strobe_s;
        end
    end

    assign sclk_rise   = sclk_s & ~sclk_prev_q;
    assign strobe_rise = strobe_s & ~strobe_prev_q;

    // ************************************************************
    // Shift register
    // ************************************************************
    logic [pdcr_pkg::WORD_W-1:0] shift_q;

    // Data is synchronised with the same latency as the clock, so the
    // level seen at the clock edge is the one the host set up.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= pdcr_pkg::WORD_RST;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[pdcr_pkg::WORD_W-2:0], data_s}; // [R15]
        end
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    logic load_main;
    logic load_denom;
    logic load_aux;

    // Only the strobe edge loads; bit clocks alone never do. [R20]
    assign load_main  = strobe_rise & ~shift_q[0]; // [R1]
    assign load_denom = strobe_rise &
        (shift_q[pdcr_pkg::SEL_W-1:0] == pdcr_pkg::SEL_DENOM); // [R16]
    assign load_aux   = strobe_rise &
        (shift_q[pdcr_pkg::SEL_W-1:0] == pdcr_pkg::SEL_AUX); // [R16]

    // ************************************************************
    // Main divider word
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_feedback_count     <= '0;
            main_fraction_numerator <= '0;
        end else if (load_main) begin
            main_feedback_count <= shift_q[pdcr_pkg::FB_LSB +:
                                           pdcr_pkg::FB_W]; // [R2]
            main_fraction_numerator <= shift_q[pdcr_pkg::FN_LSB +:
                                               pdcr_pkg::FN_W];
        end
    end

    // Counters restart; stored contents are left alone
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_counters_reset <= 1'b0;
        end else begin
            lock_counters_reset <= load_main; // [R17]
        end
    end

    // ************************************************************
    // Reference and denominator word
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_fraction_denominator <= '0;
            main_reference_divider    <= pdcr_pkg::REF_RST;
            main_loop_powerdown_bit   <= 1'b0;
        end else if (load_denom) begin
            main_fraction_denominator <= shift_q[pdcr_pkg::FD_LSB +:
                                                 pdcr_pkg::FD_W];
            main_reference_divider <= shift_q[pdcr_pkg::REF_LSB +:
                                              pdcr_pkg::REF_W];
            main_loop_powerdown_bit <= shift_q[pdcr_pkg::MAIN_PD_POS];
        end
    end

    // ************************************************************
    // Main power control
    // ************************************************************
    logic main_down_d;

    always_comb begin
        if (!enable_s) begin
            main_down_d = 1'b1; // [R7]
        end else if (|auto_powerup_word) begin
            main_down_d = 1'b0; // [R8]
        end else begin
            main_down_d = main_loop_powerdown_bit; // [R6]
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_loop_powered_down <= 1'b1;
            main_cp_hiz            <= 1'b1;
        end else begin
            main_loop_powered_down <= main_down_d; // [R6]
            main_cp_hiz            <= main_down_d; // [R6]
        end
    end

    // ************************************************************
    // Reference divider
    // ************************************************************
    logic [5:0] ref_cnt_q;

    // A zero setting is left undefined; it behaves here like one.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_cnt_q     <= pdcr_pkg::REF_RST;
            ref_div_pulse <= 1'b0;
        end else if (main_down_d) begin
            ref_cnt_q     <= 6'h01;
            ref_div_pulse <= 1'b0;
        end else if (ref_tick) begin
            if (ref_cnt_q >= main_reference_divider) begin
                ref_cnt_q     <= 6'h01; // [R5]
                ref_div_pulse <= 1'b1;
            end else begin
                ref_cnt_q     <= ref_cnt_q + 6'h01;
                ref_div_pulse <= 1'b0;
            end
        end else begin
            ref_div_pulse <= 1'b0;
        end
    end

    // ************************************************************
    // Auxiliary divider word
    // ************************************************************
    // Swallow is the low bits, main count the upper bits; with the
    // small prescaler bit 3 belongs to neither and is dropped.
    function automatic logic [3:0] aux_swallow(
        input logic [16:0] ratio,
        input logic        psc16
    );
        aux_swallow = psc16 ? ratio[3:0] : {1'b0, ratio[2:0]};
    endfunction

    logic [16:0] aux_field;

    assign aux_field = shift_q[pdcr_pkg::AUX_N_LSB +: pdcr_pkg::AUX_N_W];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aux_main_count         <= '0;
            aux_swallow_count      <= '0;
            aux_prescaler_16       <= 1'b0;
            aux_cp_gain_high       <= 1'b0;
            aux_loop_powerdown_bit <= 1'b0;
        end else if (load_aux) begin
            aux_main_count <= aux_field[16:4]; // [R9] [R11]
            aux_swallow_count <= aux_swallow(aux_field,
                shift_q[pdcr_pkg::AUX_PSC_POS]); // [R9]
            aux_prescaler_16       <= shift_q[pdcr_pkg::AUX_PSC_POS];
            aux_cp_gain_high       <= shift_q[pdcr_pkg::AUX_CPG_POS];
            aux_loop_powerdown_bit <= shift_q[pdcr_pkg::AUX_PD_POS];
        end
    end

    // ************************************************************
    // Auxiliary power control
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aux_loop_powered_down <= 1'b0;
            aux_cp_hiz            <= 1'b0;
        end else if (!aux_loop_powerdown_bit) begin
            aux_loop_powered_down <= 1'b0;
            aux_cp_hiz            <= 1'b0;
        end else if (aux_pd_immediate || aux_pump_idle) begin
            aux_loop_powered_down <= 1'b1; // [R18]
            aux_cp_hiz            <= 1'b1; // [R18]
        end
    end

endmodule

/* File: hw/pdcr_pkg.sv */
package pdcr_pkg;

    // ************************************************************
    // Serial word layout
    // ************************************************************
    localparam int unsigned WORD_W = 24;
    localparam int unsigned SEL_W  = 4;

    localparam logic [3:0] SEL_DENOM = 4'h1;
    localparam logic [3:0] SEL_AUX   = 4'h3;

    // ************************************************************
    // Main divider word fields
    // ************************************************************
    localparam int unsigned FB_W   = 11;
    localparam int unsigned FB_LSB = 13;
    localparam int unsigned FN_W   = 12;
    localparam int unsigned FN_LSB = 1;

    // ************************************************************
    // Reference and denominator word fields
    // ************************************************************
    localparam int unsigned FD_W       = 12;
    localparam int unsigned FD_LSB     = 4;
    localparam int unsigned REF_W      = 6;
    localparam int unsigned REF_LSB    = 16;
    localparam int unsigned MAIN_PD_POS = 23;

    // ************************************************************
    // Auxiliary divider word fields
    // ************************************************************
    localparam int unsigned AUX_N_W     = 17;
    localparam int unsigned AUX_N_LSB   = 4;
    localparam int unsigned AUX_PSC_POS = 21;
    localparam int unsigned AUX_CPG_POS = 22;
    localparam int unsigned AUX_PD_POS  = 23;
    localparam int unsigned AUX_B_W     = 13;
    localparam int unsigned AUX_A_W     = 4;

    // ************************************************************
    // Values after reset and synchroniser depth
    // ************************************************************
    localparam logic [23:0] WORD_RST   = 24'h000000;
    localparam logic [5:0]  REF_RST    = 6'h01;
    localparam int unsigned SYNC_STAGES = 3;

endpackage

/* File: hw/pdcr_sync.sv */
`timescale 1ns/1ps

// Three-stage synchroniser; the clean level moves only once the
// second and third stages agree, which filters single-sample glitches.
module pdcr_sync (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic pin_in,
    output logic      level_out
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
        end else begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            level_out <= 1'b0;
        end else if (stage2_q == stage3_q) begin
            level_out <= stage3_q;
        end
    end

endmodule

/* File: dv/pdcr_chk.sv */
`timescale 1ns/1ps

// ************************************************************
// Port checks
// ************************************************************
module pdcr_chk (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        latch_strobe,
    input wire logic        chip_enable,
    input wire logic [1:0]  auto_powerup_word,
    input wire logic        aux_pd_immediate,
    input wire logic [10:0] main_feedback_count,
    input wire logic [5:0]  main_reference_divider,
    input wire logic        main_loop_powerdown_bit,
    input wire logic        main_loop_powered_down,
    input wire logic        main_cp_hiz,
    input wire logic        lock_counters_reset,
    input wire logic [3:0]  aux_swallow_count,
    input wire logic        aux_prescaler_16,
    input wire logic        aux_loop_powerdown_bit,
    input wire logic        aux_loop_powered_down
);
    logic [3:0] since_strobe_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Raw pin sampled here; the block's synchroniser adds a few cycles
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) since_strobe_q <= 4'hf;
        else if ($rose(latch_strobe)) since_strobe_q <= 4'h0;
        else if (since_strobe_q != 4'hf)
            since_strobe_q <= since_strobe_q + 4'h1;
    end

    a_main_hiz_match: assert property (
        main_cp_hiz == main_loop_powered_down)
        else $error("main pump state differs from power state");
    a_enable_low_down: assert property (
        !chip_enable [*8] |-> main_loop_powered_down)
        else $error("main loop up while enable low");
    a_powerup_wins: assert property (
        (chip_enable && auto_powerup_word != 2'h0) [*8]
        |-> !main_loop_powered_down)
        else $error("auto power-up ignored");
    a_pd_bit_rules: assert property (
        (chip_enable && auto_powerup_word == 2'h0
        && $stable(main_loop_powerdown_bit)) [*8]
        |-> main_loop_powered_down == main_loop_powerdown_bit)
        else $error("power-down bit not obeyed");
    a_lock_one_cycle: assert property (
        lock_counters_reset |=> !lock_counters_reset)
        else $error("lock reset pulse too long");
    // Field and lock pulse leave the same flop edge, so they coincide
    a_main_load_lock: assert property (
        $changed(main_feedback_count) |-> lock_counters_reset)
        else $error("no lock reset with main load");
    a_load_after_strobe: assert property (
        $changed(main_feedback_count) || $changed(main_reference_divider)
        || $changed(aux_swallow_count) |-> since_strobe_q < 4'hc)
        else $error("field moved without strobe");
    a_small_psc_swallow: assert property (
        !aux_prescaler_16 |-> !aux_swallow_count[3])
        else $error("swallow bit 3 set with small prescaler");
    a_aux_pd_now: assert property (
        aux_loop_powerdown_bit && aux_pd_immediate |=> aux_loop_powered_down)
        else $error("aux not down at once");
    a_aux_up_clear: assert property (
        !aux_loop_powerdown_bit |=> !aux_loop_powered_down)
        else $error("aux down with bit clear");

    c_lock: cover property (lock_counters_reset);
    c_aux_now: cover property (aux_loop_powerdown_bit && aux_pd_immediate
        && !aux_loop_powered_down);
    c_main_up: cover property (!main_loop_powered_down);
    c_aux_down: cover property (aux_loop_powered_down);
endmodule

bind pdcr_top pdcr_chk chk_u (.*);

/* File: dv/pdcr_host.sv */
`timescale 1ns/1ps

// ************************************************************
// Host side of the three-wire link
// ************************************************************
module pdcr_host (
    input  wire logic sys_clk,
    output logic      ser_data,
    output logic      ser_clk,
    output logic      latch_strobe
);
    initial ser_data = 1'b0;
    initial ser_clk = 1'b0;
    initial latch_strobe = 1'b0;

    // Half of the 160 ns bit period
    task automatic half();
        repeat (8) @(negedge sys_clk);
    endtask

    // Low n bits of w go out MSB first; strobe only when ld is set
    task automatic send(input logic [23:0] w, input int n, input bit ld);
        for (int i = n - 1; i >= 0; i--) begin
            ser_data = w[i];
            half();
            ser_clk = 1'b1;
            half();
            ser_clk = 1'b0;
        end
        // Released data shows the inverse so a stale bit is never read
        ser_data = ~ser_data;
        half();
        latch_strobe = ld;
        half();
        latch_strobe = 1'b0;
        half();
    endtask
endmodule

/* File: dv/pdcr_top_tb.sv */
`timescale 1ns/1ps

module pdcr_top_tb;
    logic        sys_clk           = 1'b0;
    logic        reset_n           = 1'b0;
    logic        chip_enable       = 1'b0;
    logic [1:0]  auto_powerup_word = 2'h0;
    logic        aux_pd_immediate  = 1'b0;
    logic        aux_pump_idle     = 1'b0;
    logic        ref_tick          = 1'b0;
    wire         ser_data, ser_clk, latch_strobe;
    logic [12:0] aux_main_count;
    logic [11:0] main_fraction_numerator, main_fraction_denominator;
    logic [10:0] main_feedback_count;
    logic [5:0]  main_reference_divider;
    logic [3:0]  aux_swallow_count;
    logic        main_loop_powerdown_bit, main_loop_powered_down;
    logic        main_cp_hiz, ref_div_pulse, lock_counters_reset;
    logic        aux_prescaler_16, aux_cp_gain_high, aux_loop_powerdown_bit;
    logic        aux_loop_powered_down, aux_cp_hiz;
    int          fail_count, tests_run, locks, pulses;

    pdcr_top dut_u (.*);
    pdcr_host host_u (.sys_clk(sys_clk), .ser_data(ser_data),
                      .ser_clk(ser_clk), .latch_strobe(latch_strobe));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) locks <= locks + int'(lock_counters_reset);
    always @(posedge sys_clk) pulses <= pulses + int'(ref_div_pulse);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d, checks %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic tick1();
        ref_tick = 1'b1;
        wt(1);
        ref_tick = 1'b0;
        wt(3);
    endtask

    task automatic t_reset();
        chk(main_reference_divider, 6'h01);
        chk(main_loop_powered_down, 1'b1);
        chk(main_feedback_count, 11'h000);
        chk(aux_loop_powered_down, 1'b0);
    endtask

    task automatic t_words();
        int k;
        host_u.send({1'b1, 1'b1, 6'd3, 12'h5a5, 4'h1}, 24, 1'b1);
        chk(main_fraction_denominator, 12'h5a5);
        chk(main_reference_divider, 6'd3);
        chk(main_loop_powerdown_bit, 1'b1);
        k = locks;
        // Bits 3..1 are not all zero here: only bit 0 may select
        host_u.send({11'd71, 12'habc, 1'b0}, 24, 1'b1);
        chk(main_feedback_count, 11'd71);
        chk(main_fraction_numerator, 12'habc);
        chk(locks - k, 1);
        chk(main_fraction_denominator, 12'h5a5);
        host_u.send({11'd2045, 12'h001, 1'b0}, 24, 1'b1);
        chk(main_feedback_count, 11'd2045);
        k = locks;
        host_u.send(24'hfffff5, 24, 1'b1);
        host_u.send(24'hfff000, 12, 1'b0);
        chk(main_feedback_count, 11'd2045);
        chk(main_reference_divider, 6'd3);
        chk(locks - k, 0);
    endtask

    task automatic t_aux();
        host_u.send({3'b011, 17'h1ffff, 4'h3}, 24, 1'b1);
        chk(aux_main_count, 13'h1fff);
        chk(aux_swallow_count, 4'hf);
        chk(aux_prescaler_16, 1'b1);
        chk(aux_cp_gain_high, 1'b1);
        chk(aux_loop_powerdown_bit, 1'b0);
        host_u.send({3'b000, 17'h1fff7, 4'h3}, 24, 1'b1);
        chk(aux_main_count, 13'h1fff);
        chk(aux_swallow_count, 4'h7);
        chk(aux_prescaler_16, 1'b0);
        host_u.send({3'b000, 17'h00066, 4'h3}, 24, 1'b1);
        chk(aux_main_count, 13'h0006);
        chk(aux_swallow_count, 4'h6);
        host_u.send({3'b100, 17'h00070, 4'h3}, 24, 1'b1);
        chk(aux_loop_powerdown_bit, 1'b1);
        chk(aux_loop_powered_down, 1'b0);
        aux_pump_idle = 1'b1;
        wt(3);
        chk(aux_cp_hiz, 1'b1);
        aux_pump_idle = 1'b0;
        host_u.send({3'b000, 17'h00070, 4'h3}, 24, 1'b1);
        chk(aux_loop_powered_down, 1'b0);
        aux_pd_immediate = 1'b1;
        host_u.send({3'b100, 17'h00070, 4'h3}, 24, 1'b1);
        chk(aux_loop_powered_down, 1'b1);
        chk(aux_cp_hiz, 1'b1);
        aux_pd_immediate = 1'b0;
    endtask

    task automatic t_power();
        chip_enable = 1'b1;
        wt(10);
        chk(main_loop_powered_down, 1'b1);
        auto_powerup_word = 2'h2;
        wt(10);
        chk(main_cp_hiz, 1'b0);
        chip_enable = 1'b0;
        wt(10);
        chk(main_loop_powered_down, 1'b1);
        chip_enable = 1'b1;
        auto_powerup_word = 2'h0;
    endtask

    task automatic t_ref();
        int p;
        int rs [3] = '{1, 3, 63};
        for (int i = 0; i < 3; i++) begin
            // Zero is never sent: its division is undefined
            host_u.send({2'b01, 6'(rs[i]), 12'h5a5, 4'h1}, 24, 1'b1);
            chk(main_loop_powered_down, 1'b0);
            p = pulses;
            for (int k = 0; k < 70 && pulses == p; k++) tick1();
            p = pulses;
            repeat (3 * rs[i]) tick1();
            chk(pulses - p, 3);
        end
    endtask

    initial begin
        wt(4);
        reset_n = 1'b1;
        wt(6);
        t_reset();
        t_words();
        t_aux();
        t_power();
        t_ref();
        complete_run();
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        $display("unexpected at %0t: run timed out", $time);
        complete_run();
    end
endmodule
